// File: rtl/sts_regs.sv
// status and control register bank of a gas sensor and its transceiver
`timescale 1ns/10ps
`default_nettype none
module sts_regs #(
  parameter int unsigned MS_CYCLES = sts_pkg::MS_CYCLES,
  parameter logic [7:0]  FW_MAJOR  = 8'h01,  // arbitrary value
  parameter logic [7:0]  FW_MINOR  = 8'h00   // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  input  wire logic        req_bcast,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic             rsp_exc,
  output logic [15:0]      rsp_data,
  input  wire logic [15:0] fault_cond,
  output logic             bat_rd_req,
  input  wire logic        bat_rd_done,
  input  wire logic        bat_rd_ok,
  input  wire logic [15:0] bat_pct_in,
  input  wire logic [31:0] bat_min_in,
  output logic             radio_sleep,
  output logic             mcu_reset,
  output logic             radio_reset
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: the millisecond divider needs at least two states
  generate
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // state of the register bank
  typedef struct packed {
    logic [15:0]         fault;
    logic [15:0]         pct;
    logic [15:0]         mins;
    logic [15:0]         sleep;
    logic [15:0]         ctrl;
    logic                det;
    logic                bfail;
    logic [15:0]         bcnt;
    sts_pkg::sts_bat_type bst;
    logic [2:0]          tries;
    logic [2:0]          poll;
    logic                rsp_valid;
    logic                rsp_exc;
    logic [15:0]         rsp_data;
    logic                mcu_rst;
    logic                radio_rst;
  } sts_state_type;

  localparam sts_state_type RESET_STATE = '{
    fault:     16'h0000,
    pct:       16'h0000,
    mins:      16'h0000,
    sleep:     16'h0000,
    ctrl:      sts_pkg::CTRL_RESET,
    det:       1'b0,
    bfail:     1'b0,
    bcnt:      16'h0000,
    bst:       sts_pkg::BAT_IDLE,
    tries:     3'h0,
    poll:      3'h0,
    rsp_valid: 1'b0,
    rsp_exc:   1'b0,
    rsp_data:  16'h0000,
    mcu_rst:   1'b0,
    radio_rst: 1'b0
  };

  sts_state_type q_ff;
  sts_state_type nxt_q;

  sts_time_if tif ();

  ////////////////////////////////////////////////////////////////////////
  // address decoding shared by the read and write paths
  function automatic logic reg_known(input logic [15:0] addr);
    reg_known = (addr == sts_pkg::A_FAULT)     ||
                (addr == sts_pkg::A_BAT_PCT)   ||
                (addr == sts_pkg::A_BAT_MIN)   ||
                (addr == sts_pkg::A_FW_VER)    ||
                (addr == sts_pkg::A_SLEEP)     ||
                (addr == sts_pkg::A_CTRL)      ||
                (addr == sts_pkg::A_STATUS)    ||
                (addr == sts_pkg::A_BAT_FAILS) ||
                (addr == sts_pkg::A_TS_SEC_HI) ||
                (addr == sts_pkg::A_TS_SEC_LO) ||
                (addr == sts_pkg::A_TS_MS);
  endfunction

  // function code classification
  function automatic logic is_write(input logic [7:0] func);
    is_write = (func == sts_pkg::FN_WRITE_ONE) ||
               (func == sts_pkg::FN_WRITE_MANY);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational views of the current state
  logic [15:0] status_word;
  logic [15:0] fw_word;
  logic [15:0] rd_value;
  logic        req_rd;
  logic        req_wr;
  logic        req_bad_fn;
  logic        wr_hit;
  logic        poll_due;
  logic        bat_fail_now;

  // status word: fixed ones plus the two battery flags
  always_comb begin
    status_word                       = sts_pkg::ST_FIXED_ONES;
    status_word[sts_pkg::ST_BAT_DET]  = q_ff.det;
    status_word[sts_pkg::ST_BAT_FAIL] = q_ff.bfail;
  end

  assign fw_word    = {FW_MAJOR, FW_MINOR};
  assign req_rd     = req_valid && (req_func == sts_pkg::FN_READ);
  assign req_wr     = req_valid && is_write(req_func);
  assign req_bad_fn = req_valid && !req_rd && !req_wr;
  assign wr_hit     = req_wr && reg_known(req_addr);

  // poll fires on the second tick that completes the interval
  assign poll_due = tif.sec_tick &&
                    (q_ff.poll == sts_pkg::POLL_SECONDS - 3'h1);

  // a read is declared failed only after the last retry fails
  assign bat_fail_now = (q_ff.bst == sts_pkg::BAT_WAIT) && bat_rd_done &&
                        !bat_rd_ok &&
                        (q_ff.tries == sts_pkg::BAT_TRIES - 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped words read zero when exceptions are off
  always_comb begin
    if (req_addr == sts_pkg::A_FAULT) begin
      rd_value = q_ff.fault;
    end else if (req_addr == sts_pkg::A_BAT_PCT) begin
      rd_value = q_ff.pct;
    end else if (req_addr == sts_pkg::A_BAT_MIN) begin
      rd_value = q_ff.mins;
    end else if (req_addr == sts_pkg::A_FW_VER) begin
      rd_value = fw_word;
    end else if (req_addr == sts_pkg::A_SLEEP) begin
      rd_value = q_ff.sleep;
    end else if (req_addr == sts_pkg::A_CTRL) begin
      rd_value = q_ff.ctrl;
    end else if (req_addr == sts_pkg::A_STATUS) begin
      rd_value = status_word;
    end else if (req_addr == sts_pkg::A_BAT_FAILS) begin
      rd_value = q_ff.bcnt;
    end else if (req_addr == sts_pkg::A_TS_SEC_HI) begin
      rd_value = tif.sec_count[31:16];
    end else if (req_addr == sts_pkg::A_TS_SEC_LO) begin
      rd_value = tif.sec_count[15:0];
    end else if (req_addr == sts_pkg::A_TS_MS) begin
      rd_value = {6'h00, tif.ms_count};
    end else begin
      rd_value = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_q           = q_ff;
    nxt_q.rsp_valid = 1'b0;
    nxt_q.rsp_exc   = 1'b0;
    nxt_q.mcu_rst   = 1'b0;
    nxt_q.radio_rst = 1'b0;

    // fault flags track their conditions every cycle, no acknowledge
    nxt_q.fault = fault_cond & sts_pkg::FAULT_MASK;
    nxt_q.fault[sts_pkg::FB_GLOBAL] = fault_cond[sts_pkg::FB_GLOBAL] ||
                                      (|(fault_cond & sts_pkg::FAULT_MASK));

    // sleep countdown: a fresh write wins over the per-second step
    if (wr_hit && (req_addr == sts_pkg::A_SLEEP)) begin
      nxt_q.sleep = req_wdata;
    end else if (tif.sec_tick && (q_ff.sleep != 16'h0000)) begin
      nxt_q.sleep = q_ff.sleep - 16'h0001;
    end

    // control: only the exception enable is kept, reset bits are strobes
    if (wr_hit && (req_addr == sts_pkg::A_CTRL)) begin
      nxt_q.ctrl      = req_wdata & sts_pkg::CTRL_KEEP;
      nxt_q.mcu_rst   = req_wdata[sts_pkg::CT_RST_ALL] ||
                        req_wdata[sts_pkg::CT_RST_MCU];
      nxt_q.radio_rst = req_wdata[sts_pkg::CT_RST_ALL];
    end

    // failure counter: written value first, then a declared failure adds
    // on top so an event landing on the clearing write is never lost
    if (wr_hit && (req_addr == sts_pkg::A_BAT_FAILS)) begin
      nxt_q.bcnt = req_wdata;
    end
    if (bat_fail_now) begin
      nxt_q.bcnt = nxt_q.bcnt + sts_pkg::FAIL_STEP;
    end

    // poll interval counter in whole seconds
    if (tif.sec_tick) begin
      if (poll_due) begin
        nxt_q.poll = 3'h0;
      end else begin
        nxt_q.poll = q_ff.poll + 3'h1;
      end
    end

    // battery poll sequencer with retries
    case (q_ff.bst)
      sts_pkg::BAT_IDLE: begin
        if (poll_due) begin
          nxt_q.bst   = sts_pkg::BAT_REQ;
          nxt_q.tries = 3'h0;
        end
      end
      sts_pkg::BAT_REQ: begin
        nxt_q.bst = sts_pkg::BAT_WAIT;
      end
      sts_pkg::BAT_WAIT: begin
        if (bat_rd_done && bat_rd_ok) begin
          nxt_q.det   = 1'b1;
          nxt_q.bfail = 1'b0;
          // percent clamps at full scale, minutes saturate
          nxt_q.pct   = (bat_pct_in > sts_pkg::PCT_MAX) ? sts_pkg::PCT_MAX
                                                        : bat_pct_in;
          nxt_q.mins  = (|bat_min_in[31:16]) ? sts_pkg::MIN_MAX
                                             : bat_min_in[15:0];
          nxt_q.bst   = sts_pkg::BAT_IDLE;
        end else if (bat_fail_now) begin
          nxt_q.bfail = q_ff.det;
          nxt_q.bst   = sts_pkg::BAT_IDLE;
        end else if (bat_rd_done) begin
          nxt_q.tries = q_ff.tries + 3'h1;
          nxt_q.bst   = sts_pkg::BAT_REQ;
        end
      end
      default: begin
        nxt_q.bst = sts_pkg::BAT_IDLE;
      end
    endcase

    // answers: the register port is served whether or not the radio
    // sleeps; broadcasts are acted on but never answered
    if (req_valid && !req_bcast) begin
      nxt_q.rsp_valid = 1'b1;
      if (req_bad_fn && q_ff.ctrl[sts_pkg::CT_EXC_EN]) begin
        nxt_q.rsp_exc  = 1'b1;
        nxt_q.rsp_data = {8'h00, sts_pkg::EX_BAD_FUNC};
      end else if (!reg_known(req_addr) && q_ff.ctrl[sts_pkg::CT_EXC_EN]) begin
        nxt_q.rsp_exc  = 1'b1;
        nxt_q.rsp_data = {8'h00, sts_pkg::EX_BAD_ADDR};
      end else if (req_rd) begin
        nxt_q.rsp_data = rd_value;
      end else begin
        // writes echo the word, read-only targets stay unchanged
        nxt_q.rsp_data = req_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= RESET_STATE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // uptime counters; a processor reset restarts them from zero
  assign tif.clear = q_ff.mcu_rst;

  sts_timebase #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timebase (
    .core_clk (core_clk),
    .reset    (reset),
    .tif      (tif.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rsp_valid   = q_ff.rsp_valid;
  assign rsp_exc     = q_ff.rsp_exc;
  assign rsp_data    = q_ff.rsp_data;
  assign bat_rd_req  = (q_ff.bst == sts_pkg::BAT_REQ);
  assign radio_sleep = (q_ff.sleep != 16'h0000);
  assign mcu_reset   = q_ff.mcu_rst;
  assign radio_reset = q_ff.radio_rst;

endmodule // sts_regs
`default_nettype wire

// File: rtl/sts_pkg.sv
// constants and types shared by the sensor/transceiver status register bank
package sts_pkg;

  // timing: clock period and the millisecond tick derived from it
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_PERIOD_NS  = 1000000;
  localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  MS_LAST       = 10'h3e7;   // 999 then wrap

  // battery polling
  localparam logic [2:0]  POLL_SECONDS  = 3'h5;
  localparam logic [2:0]  BAT_TRIES     = 3'h4;
  localparam logic [15:0] FAIL_STEP     = 16'h0004;
  localparam logic [15:0] PCT_MAX       = 16'h0064;
  localparam logic [15:0] MIN_MAX       = 16'hffff;

  // register word addresses
  localparam logic [15:0] A_FAULT       = 16'h0005;
  localparam logic [15:0] A_BAT_PCT     = 16'h2007;
  localparam logic [15:0] A_BAT_MIN     = 16'h2008;
  localparam logic [15:0] A_FW_VER      = 16'h2009;
  localparam logic [15:0] A_SLEEP       = 16'h200a;
  localparam logic [15:0] A_CTRL        = 16'h200b;
  localparam logic [15:0] A_STATUS      = 16'h200c;
  localparam logic [15:0] A_BAT_FAILS   = 16'h200e;
  localparam logic [15:0] A_TS_SEC_HI   = 16'h2010;
  localparam logic [15:0] A_TS_SEC_LO   = 16'h2011;
  localparam logic [15:0] A_TS_MS       = 16'h2012;

  // fault word layout
  localparam int unsigned FB_GLOBAL     = 0;
  localparam logic [15:0] FAULT_MASK    = 16'h5ae6;  // defined flags, summary excluded

  // status word layout
  localparam int unsigned ST_BAT_DET    = 4;
  localparam int unsigned ST_BAT_FAIL   = 5;
  localparam logic [15:0] ST_FIXED_ONES = 16'h0044;

  // control word layout
  localparam int unsigned CT_EXC_EN     = 11;
  localparam int unsigned CT_RST_ALL    = 7;
  localparam int unsigned CT_RST_MCU    = 6;
  localparam logic [15:0] CTRL_KEEP     = 16'h0800;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;

  // request function codes and exception codes
  localparam logic [7:0]  FN_READ       = 8'h03;
  localparam logic [7:0]  FN_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FN_WRITE_MANY = 8'h10;
  localparam logic [7:0]  EX_BAD_FUNC   = 8'h01;
  localparam logic [7:0]  EX_BAD_ADDR   = 8'h02;

  // battery poll sequencer states
  typedef enum logic [2:0] {
    BAT_IDLE = 3'b001,
    BAT_REQ  = 3'b010,
    BAT_WAIT = 3'b100
  } sts_bat_type;

endpackage

// File: rtl/sts_time_if.sv
// time base signals passed between the register core and the timer
`timescale 1ns/10ps
`default_nettype none
interface sts_time_if;
  logic        clear;
  logic        ms_tick;
  logic        sec_tick;
  logic [9:0]  ms_count;
  logic [31:0] sec_count;

  modport timer (input clear, output ms_tick, output sec_tick,
                 output ms_count, output sec_count);
  modport core  (output clear, input ms_tick, input sec_tick,
                 input ms_count, input sec_count);
endinterface
`default_nettype wire

// File: rtl/sts_timebase.sv
// millisecond and seconds uptime counters
`timescale 1ns/10ps
`default_nettype none
module sts_timebase #(
  parameter int unsigned MS_CYCLES = sts_pkg::MS_CYCLES
) (
  input  wire logic   core_clk,
  input  wire logic   reset,
  sts_time_if.timer   tif
);

  localparam int unsigned CW = $clog2(MS_CYCLES);

  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [9:0]    ms;
    logic [31:0]   sec;
    logic          ms_tick;
    logic          sec_tick;
  } sts_tb_state_type;

  sts_tb_state_type q_ff;
  sts_tb_state_type nxt_q;

  ////////////////////////////////////////////////////////////////////////
  // seconds advance on the very cycle the millisecond count wraps
  always_comb begin
    nxt_q          = q_ff;
    nxt_q.ms_tick  = 1'b0;
    nxt_q.sec_tick = 1'b0;
    if (tif.clear) begin
      nxt_q = '0;
    end else if (q_ff.cyc == CW'(MS_CYCLES - 1)) begin
      nxt_q.cyc     = '0;
      nxt_q.ms_tick = 1'b1;
      if (q_ff.ms == sts_pkg::MS_LAST) begin
        nxt_q.ms       = '0;
        nxt_q.sec      = q_ff.sec + 32'h1;
        nxt_q.sec_tick = 1'b1;
      end else begin
        nxt_q.ms = q_ff.ms + 10'h1;
      end
    end else begin
      nxt_q.cyc = q_ff.cyc + CW'(1);
    end
  end

  // state register, cleared at power-up
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tif.ms_tick   = q_ff.ms_tick;
  assign tif.sec_tick  = q_ff.sec_tick;
  assign tif.ms_count  = q_ff.ms;
  assign tif.sec_count = q_ff.sec;

endmodule // sts_timebase
`default_nettype wire

// File: test/sts_regs_monitor.sv
// port-level checks on the status register bank
`timescale 1ns/10ps
`default_nettype none
module sts_regs_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic        req_bcast,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_exc,
  input wire logic [15:0] rsp_data,
  input wire logic [15:0] fault_cond,
  input wire logic        radio_sleep,
  input wire logic        mcu_reset,
  input wire logic        radio_reset
);
  //////////////////////////////////////////////////////////////////////////////
  // request decodes shared by the checks; broadcasts are acted on too
  wire logic        wr_on   = req_valid && (req_func == sts_pkg::FN_WRITE_ONE ||
                                            req_func == sts_pkg::FN_WRITE_MANY);
  wire logic        wr_slp  = wr_on && req_addr == sts_pkg::A_SLEEP;
  wire logic        wr_ctl  = wr_on && req_addr == sts_pkg::A_CTRL;
  wire logic        rd_flt  = req_valid && !req_bcast && req_func == sts_pkg::FN_READ &&
                              req_addr == sts_pkg::A_FAULT;
  wire logic [15:0] flt_exp = (fault_cond & sts_pkg::FAULT_MASK) |
                              {15'h0, |(fault_cond & (sts_pkg::FAULT_MASK | 16'h0001))};

  //////////////////////////////////////////////////////////////////////////////
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  rsp_follows_a: assert property (req_valid && !req_bcast |=> rsp_valid)
    else $error("request not answered one cycle later");
  bcast_quiet_a: assert property (req_valid && req_bcast |=> !rsp_valid)
    else $error("broadcast request was answered");
  rsp_cause_a: assert property (rsp_valid |-> $past(req_valid && !req_bcast))
    else $error("answer without a request");
  reset_idle_a: assert property ($fell(reset) |-> !rsp_valid && !radio_sleep && !mcu_reset)
    else $error("outputs not idle after reset");
  sleep_set_a: assert property (wr_slp && req_wdata != 16'h0000 |=> radio_sleep)
    else $error("radio awake after nonzero countdown write");
  sleep_clear_a: assert property (wr_slp && req_wdata == 16'h0000 |=> !radio_sleep)
    else $error("radio asleep after zero countdown write");
  ro_echo_a: assert property (wr_on && !req_bcast && req_addr == sts_pkg::A_STATUS |=>
    !rsp_exc && rsp_data == $past(req_wdata))
    else $error("read-only write not echoed");
  rst_both_a: assert property (wr_ctl && req_wdata[7] |=> mcu_reset && radio_reset)
    else $error("full reset strobes missing");
  rst_mcu_a: assert property (wr_ctl && req_wdata[7:6] == 2'b01 |=> mcu_reset && !radio_reset)
    else $error("cpu-only reset strobes wrong");
  radio_cause_a: assert property (radio_reset |-> $past(wr_ctl && req_wdata[7]))
    else $error("radio reset without a control write");
  fault_read_a: assert property (rd_flt && $stable(fault_cond) |=> rsp_data == $past(flt_exp))
    else $error("fault word does not follow conditions");
endmodule // sts_regs_monitor

bind sts_regs sts_regs_monitor i_sts_regs_monitor (
  .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_bcast(req_bcast),
  .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
  .rsp_exc(rsp_exc), .rsp_data(rsp_data), .fault_cond(fault_cond),
  .radio_sleep(radio_sleep), .mcu_reset(mcu_reset), .radio_reset(radio_reset)
);
`default_nettype wire

// File: test/sts_battery_model.sv
// battery pack answering read attempts on the battery link
`timescale 1ns/10ps
`default_nettype none
module sts_battery_model (
  input  wire logic        core_clk,
  input  wire logic        bat_rd_req,
  input  wire logic        fail_mode,
  input  wire logic [15:0] pct_val,
  input  wire logic [31:0] min_val,
  output logic             bat_rd_done = 1'b0,
  output logic             bat_rd_ok = 1'b0,
  output logic [15:0]      bat_pct_in = 16'h0000,
  output logic [31:0]      bat_min_in = 32'h0000_0000,
  output logic [7:0]       attempts = 8'h00
);
  logic [3:0] wait_ff = 4'h0;
  logic       slow_ff = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // answers alternate prompt and slow; data is scrambled outside an answer so
  // the bank cannot get away with sampling it at the wrong time
  always @(posedge core_clk) begin
    bat_rd_done <= 1'b0;
    bat_rd_ok   <= ~bat_rd_ok;
    bat_pct_in  <= ~bat_pct_in;
    bat_min_in  <= ~bat_min_in;
    if (bat_rd_req) begin
      attempts <= attempts + 8'h01;
      wait_ff  <= slow_ff ? 4'h9 : 4'h1;
      slow_ff  <= ~slow_ff;
    end else if (wait_ff == 4'h1) begin
      wait_ff     <= 4'h0;
      bat_rd_done <= 1'b1;
      bat_rd_ok   <= ~fail_mode;
      bat_pct_in  <= pct_val;
      bat_min_in  <= min_val;
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule // sts_battery_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int MSC = 4;
  localparam int SEC = 1000 * MSC;
  logic        core_clk, reset, req_valid, req_bcast, rsp_valid, rsp_exc, e, sl;
  logic [7:0]  req_func;
  logic [15:0] req_addr, req_wdata, rsp_data, fault_cond, q, pct_val, bat_pct_in;
  logic        bat_rd_req, bat_rd_done, bat_rd_ok, radio_sleep, mcu_reset, radio_reset;
  logic        fail_mode;
  logic [31:0] min_val, bat_min_in;
  logic [7:0]  attempts;
  logic [1:0]  rr;
  int          fails, samples_checked;

  sts_regs #(.MS_CYCLES(MSC), .FW_MAJOR(8'h12), .FW_MINOR(8'h34)) i_sts_regs (
    .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_bcast(req_bcast),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data),
    .fault_cond(fault_cond), .bat_rd_req(bat_rd_req), .bat_rd_done(bat_rd_done),
    .bat_rd_ok(bat_rd_ok), .bat_pct_in(bat_pct_in), .bat_min_in(bat_min_in),
    .radio_sleep(radio_sleep), .mcu_reset(mcu_reset), .radio_reset(radio_reset));
  sts_battery_model i_sts_battery_model (
    .core_clk(core_clk), .bat_rd_req(bat_rd_req), .fail_mode(fail_mode),
    .pct_val(pct_val), .min_val(min_val), .bat_rd_done(bat_rd_done),
    .bat_rd_ok(bat_rd_ok), .bat_pct_in(bat_pct_in), .bat_min_in(bat_min_in),
    .attempts(attempts));

  //////////////////////////////////////////////////////////////////////////////
  // shared compare, bus cycle and verdict
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held one edge; answer sampled settled 1 ns after the taking edge
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, d, input logic bc = 1'b0);
    req_func  <= f;
    req_addr  <= a;
    req_wdata <= d;
    req_bcast <= bc;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    q  = rsp_data;
    e  = rsp_exc;
    sl = radio_sleep;
    rr = {mcu_reset, radio_reset};
    chk(rsp_valid, !bc);
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, exp);
    xfer(sts_pkg::FN_READ, a, 16'h0000);
    chk({e, q}, {1'b0, exp});
  endtask
  task automatic wr(input logic [15:0] a, d);
    xfer(sts_pkg::FN_WRITE_ONE, a, d);
    chk({e, q}, {1'b0, d});
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_access;
    rd(sts_pkg::A_STATUS, 16'h0044);
    rd(sts_pkg::A_CTRL, 16'h0000);
    rd(sts_pkg::A_SLEEP, 16'h0000);
    chk(radio_sleep, 1'b0);
    rd(sts_pkg::A_TS_SEC_HI, 16'h0000);
    rd(sts_pkg::A_FW_VER, 16'h1234);
    wr(sts_pkg::A_STATUS, 16'hffff);
    rd(sts_pkg::A_STATUS, 16'h0044);
    rd(16'h2000, 16'h0000);
    wr(sts_pkg::A_CTRL, 16'h0800);
    rd(sts_pkg::A_CTRL, 16'h0800);
    xfer(sts_pkg::FN_READ, 16'h2000, 16'h0000);
    chk({e, q}, 17'h10002);
    xfer(8'h04, sts_pkg::A_STATUS, 16'h0000);
    chk({e, q}, 17'h10001);
    wr(sts_pkg::A_CTRL, 16'h0000);
  endtask
  task automatic t_faults;
    logic [15:0] x;
    for (int i = 0; i < 17; i++) begin
      x = (i == 16) ? 16'hffff : 16'h0001 << i;
      fault_cond <= x;
      @(posedge core_clk);
      rd(sts_pkg::A_FAULT, (x & sts_pkg::FAULT_MASK) |
         {15'h0, |(x & (sts_pkg::FAULT_MASK | 16'h0001))});
    end
    fault_cond <= 16'h0000;
    @(posedge core_clk);
    rd(sts_pkg::A_FAULT, 16'h0000);
  endtask
  task automatic t_sleep;
    int n;
    xfer(sts_pkg::FN_WRITE_ONE, sts_pkg::A_SLEEP, 16'h0002, 1'b1);
    chk(sl, 1'b1);
    xfer(sts_pkg::FN_READ, sts_pkg::A_SLEEP, 16'h0000);
    chk(q == 16'h0002 || q == 16'h0001, 1'b1);
    n = 0;
    while (radio_sleep === 1'b1 && n < 3 * SEC) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n > SEC - 8 && n <= 2 * SEC, 1'b1);
    @(posedge core_clk);
    rd(sts_pkg::A_SLEEP, 16'h0000);
    xfer(sts_pkg::FN_WRITE_MANY, sts_pkg::A_SLEEP, 16'h0001);
    chk({sl, q}, 17'h10001);
    wr(sts_pkg::A_SLEEP, 16'h0000);
    chk(sl, 1'b0);
  endtask
  // wait for the next poll, let every attempt finish
  task automatic poll(input logic fm, input logic [15:0] p, input logic [31:0] m);
    int n;
    fail_mode <= fm;
    pct_val   <= p;
    min_val   <= m;
    n = 0;
    while (bat_rd_req !== 1'b1 && n < 25000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n < 25000, 1'b1);
    repeat (60) @(posedge core_clk);
  endtask
  task automatic t_bat;
    logic [7:0] a0;
    poll(1'b0, 16'h0096, 32'h0001_2345);
    rd(sts_pkg::A_STATUS, 16'h0054);
    rd(sts_pkg::A_BAT_PCT, 16'h0064);
    rd(sts_pkg::A_BAT_MIN, 16'hffff);
    a0 = attempts;
    poll(1'b1, 16'h0011, 32'h0000_0022);
    chk(attempts - a0, 8'h04);
    rd(sts_pkg::A_STATUS, 16'h0074);
    rd(sts_pkg::A_BAT_FAILS, 16'h0004);
    wr(sts_pkg::A_BAT_FAILS, 16'h0000);
    poll(1'b0, 16'h0037, 32'h0000_1234);
    rd(sts_pkg::A_STATUS, 16'h0054);
    rd(sts_pkg::A_BAT_PCT, 16'h0037);
    rd(sts_pkg::A_BAT_MIN, 16'h1234);
    rd(sts_pkg::A_BAT_FAILS, 16'h0000);
  endtask
  task automatic t_ctrl;
    xfer(sts_pkg::FN_READ, sts_pkg::A_TS_SEC_LO, 16'h0000);
    chk(q != 16'h0000, 1'b1);
    wr(sts_pkg::A_CTRL, 16'h0080);
    chk(rr, 2'b11);
    rd(sts_pkg::A_TS_SEC_LO, 16'h0000);
    rd(sts_pkg::A_CTRL, 16'h0000);
    wr(sts_pkg::A_CTRL, 16'h0040);
    chk(rr, 2'b10);
  endtask
  // two reads exactly one second apart see one step and the same millisecond
  task automatic t_time;
    logic [15:0] s0, m0;
    xfer(sts_pkg::FN_READ, sts_pkg::A_TS_SEC_LO, 16'h0000);
    s0 = q;
    xfer(sts_pkg::FN_READ, sts_pkg::A_TS_MS, 16'h0000);
    m0 = q;
    chk(m0 < 16'h03e8, 1'b1);
    repeat (SEC - 4) @(posedge core_clk);
    rd(sts_pkg::A_TS_SEC_LO, s0 + 16'h0001);
    rd(sts_pkg::A_TS_MS, m0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // clock, main sequence and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {reset, req_valid, req_bcast, fail_mode} = 4'h8;
    {req_func, req_addr, req_wdata, fault_cond} = 56'h0;
    {pct_val, min_val} = 48'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_access;
    t_faults;
    t_sleep;
    t_bat;
    t_ctrl;
    t_time;
    report_and_stop;
  end
  // the run needs about 64000 cycles, mostly waiting for battery polls
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
